// ===== rtl/brc_pkg.sv
// Shared types and constants for the boot, reset and clock configuration block.
// Assumes a single 125 MHz reference clock and board straps that may be left floating.
package brc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int HARD_HOLD_NS = 1000;
    localparam int HARD_HOLD_CYC = (HARD_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CPU_RST_NS = 80;
    localparam int CPU_RST_CYC = (CPU_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // Strap patterns: floating mask and driven level per pin
    // ------------------------------------------------------------
    localparam logic [5:0] BOOT_PAT_SYNC_ADDRESS_DATA_MULTIPLEXED = 6'h20;  // F00
    localparam logic [5:0] BOOT_PAT_ASYNC_ADDRESS_DATA_MULTIPLEXED = 6'h21; // F01
    localparam logic [5:0] BOOT_PAT_USB = 6'h23;         // F11
    localparam logic [5:0] BOOT_PAT_I2C_ONLY = 6'h28;    // F0F
    localparam logic [5:0] BOOT_PAT_I2C_FB = 6'h2a;      // F1F
    localparam logic [5:0] BOOT_PAT_SPI_FB = 6'h1c;      // 1FF
    localparam logic [5:0] BOOT_PAT_ASYNC_SRAM = 6'h11;  // 0F1

    localparam logic [2:0] CLK_SEL_XTAL_19M2 = 3'h0;
    localparam logic [2:0] CLK_SEL_EXT_19M2 = 3'h4;
    localparam logic [2:0] CLK_SEL_EXT_26M = 3'h5;
    localparam logic [2:0] CLK_SEL_EXT_38M4 = 3'h6;
    localparam logic [2:0] CLK_SEL_EXT_52M = 3'h7;

    // PLL ratios giving one core rate (416 MHz) from every input
    localparam logic [7:0] PLL_FB_19M2 = 8'h41;
    localparam logic [3:0] PLL_REF_19M2 = 4'h3;
    localparam logic [7:0] PLL_FB_26M = 8'h10;
    localparam logic [3:0] PLL_REF_26M = 4'h1;
    localparam logic [7:0] PLL_FB_38M4 = 8'h41;
    localparam logic [3:0] PLL_REF_38M4 = 4'h6;
    localparam logic [7:0] PLL_FB_52M = 8'h08;
    localparam logic [3:0] PLL_REF_52M = 4'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BRC_SRC_SYNC_ADDRESS_DATA_MULTIPLEXED = 3'b000,
        BRC_SRC_ASYNC_ADDRESS_DATA_MULTIPLEXED = 3'b001,
        BRC_SRC_USB = 3'b010,
        BRC_SRC_I2C = 3'b011,
        BRC_SRC_SPI = 3'b100,
        BRC_SRC_ASYNC_SRAM = 3'b101,
        BRC_SRC_NONE = 3'b110
    } brc_src_e;

    typedef enum logic [2:0] {
        BRC_ST_HARD = 3'b000,
        BRC_ST_SAMPLE = 3'b001,
        BRC_ST_LOAD = 3'b010,
        BRC_ST_RUN = 3'b011,
        BRC_ST_CPU_RST = 3'b100,
        BRC_ST_FAIL = 3'b101
    } brc_state_e;

    typedef struct packed {
        logic [2:0] level;
        logic [2:0] floating;
    } brc_strap_s;

    typedef struct packed {
        logic use_crystal;
        logic sel_invalid;
        logic [7:0] pll_fb;
        logic [3:0] pll_ref;
    } brc_clk_cfg_s;

    typedef struct packed {
        brc_state_e state;
        logic [CNT_W-1:0] cnt;
        brc_src_e boot_src;
        logic fallback_ok;
        logic fallback_used;
        logic boot_start;
        logic fw_loaded;
        logic [1:0] soft_prev;
        brc_clk_cfg_s clk_cfg;
    } brc_state_s;

endpackage : brc_pkg

// ===== rtl/brc_sync.sv
// Two-flop synchroniser for board-level pins.
// Assumes inputs are quasi-static or level signals; no pulse capture.
`timescale 1ns/1ps
module brc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule : brc_sync

// ===== rtl/brc_boot_reset_clock.sv
// Power-on configuration: hard and soft reset sequencing, boot source and reference clock decode.
// Assumes an on-chip boot loader driven through start/done/fail and a processor soft reset port.
//
// What this block does
// - Boot from USB, I2C, SPI, or multiplexed parallel port async or sync.
// - Boot straps F00 sync parallel, F01 async parallel, F11 USB boot.
// - I2C or SPI fall-back settings switch to USB boot when serial load fails.
// - Low hard reset pin starts a hard reset.
// - All pins held high impedance while hard reset is active.
// - After hard reset the boot loader runs and sets pins for the chosen source.
// - Processor soft reset bits give two soft reset kinds.
// - Processor-only soft reset restarts the processor and keeps loaded firmware.
// - Whole-device soft reset acts as hard reset; firmware must reload.
// - Crystal or external reference clock accepted; unused clock pins may float.
// - Clock straps 000 crystal 19.2; 100..111 external 19.2, 26, 38.4, 52 MHz.
// - PLL ratio follows input frequency so the core rate stays fixed.
`timescale 1ns/1ps
module brc_boot_reset_clock
    import brc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic hard_reset_pin_n,
    input wire logic [2:0] boot_select_straps,
    input wire logic [2:0] boot_select_float,
    input wire logic [2:0] clock_freq_select_straps,
    input wire logic [1:0] soft_reset_control,
    input wire logic boot_done,
    input wire logic boot_fail,
    output logic io_tristate,
    output logic cpu_reset,
    output logic boot_start,
    output brc_src_e boot_source,
    output logic pin_config_valid,
    output logic usb_fallback_used,
    output logic fw_loaded,
    output logic boot_failed,
    output brc_clk_cfg_s clk_cfg
);

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------

    // Floating pins read as 'F'; the level of a floating pin is ignored
    function automatic brc_src_e decode_boot(input brc_strap_s s);
        logic [5:0] pat;
        pat = {s.floating, s.level & ~s.floating};
        unique case (pat)
            BOOT_PAT_SYNC_ADDRESS_DATA_MULTIPLEXED: decode_boot = BRC_SRC_SYNC_ADDRESS_DATA_MULTIPLEXED;
            BOOT_PAT_ASYNC_ADDRESS_DATA_MULTIPLEXED: decode_boot = BRC_SRC_ASYNC_ADDRESS_DATA_MULTIPLEXED;
            BOOT_PAT_USB: decode_boot = BRC_SRC_USB;
            BOOT_PAT_I2C_ONLY, BOOT_PAT_I2C_FB: decode_boot = BRC_SRC_I2C;
            BOOT_PAT_SPI_FB: decode_boot = BRC_SRC_SPI;
            BOOT_PAT_ASYNC_SRAM: decode_boot = BRC_SRC_ASYNC_SRAM;
            default: decode_boot = BRC_SRC_NONE;
        endcase
    endfunction : decode_boot

    function automatic logic decode_fallback(input brc_strap_s s);
        logic [5:0] pat;
        pat = {s.floating, s.level & ~s.floating};
        decode_fallback = (pat == BOOT_PAT_I2C_FB) || (pat == BOOT_PAT_SPI_FB);
    endfunction : decode_fallback

    // One core rate from every reference: ratio chosen per input frequency
    function automatic brc_clk_cfg_s decode_clk(input logic [2:0] sel);
        brc_clk_cfg_s c;
        c = '{use_crystal: 1'b0, sel_invalid: 1'b0, pll_fb: PLL_FB_19M2, pll_ref: PLL_REF_19M2};
        unique case (sel)
            CLK_SEL_XTAL_19M2: c.use_crystal = 1'b1;
            CLK_SEL_EXT_19M2: c.use_crystal = 1'b0;
            CLK_SEL_EXT_26M: begin
                c.pll_fb = PLL_FB_26M;
                c.pll_ref = PLL_REF_26M;
            end
            CLK_SEL_EXT_38M4: begin
                c.pll_fb = PLL_FB_38M4;
                c.pll_ref = PLL_REF_38M4;
            end
            CLK_SEL_EXT_52M: begin
                c.pll_fb = PLL_FB_52M;
                c.pll_ref = PLL_REF_52M;
            end
            default: begin
                // Unlisted codes fall back to the crystal rather than an unknown ratio
                c.use_crystal = 1'b1;
                c.sel_invalid = 1'b1;
            end
        endcase
        decode_clk = c;
    endfunction : decode_clk

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic hard_n_sync;
    brc_strap_s boot_strap_sync;
    logic [2:0] clk_strap_sync;

    brc_sync #(
        .WIDTH(10),
        .RESET_VAL(10'h000)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .din({hard_reset_pin_n, boot_select_straps, boot_select_float, clock_freq_select_straps}),
        .dout({hard_n_sync, boot_strap_sync, clk_strap_sync})
    );

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    brc_state_s st;
    brc_state_s next_st;
    logic cpu_edge;
    logic whole_edge;

    assign cpu_edge = soft_reset_control[0] && !st.soft_prev[0];
    assign whole_edge = soft_reset_control[1] && !st.soft_prev[1];

    // Sequencing; pin low always wins, whole-device beats cpu-only
    always_comb begin
        next_st = st;
        next_st.boot_start = 1'b0;
        next_st.soft_prev = soft_reset_control;
        if (!hard_n_sync) begin
            next_st.state = BRC_ST_HARD;
            next_st.cnt = '0;
            next_st.fw_loaded = 1'b0;
        end else begin
            unique case (st.state)
                BRC_ST_HARD: begin
                    next_st.fw_loaded = 1'b0;
                    if (st.cnt == CNT_W'(HARD_HOLD_CYC - 1)) begin
                        next_st.state = BRC_ST_SAMPLE;
                        next_st.cnt = '0;
                    end else begin
                        next_st.cnt = st.cnt + 1'b1;
                    end
                end
                BRC_ST_SAMPLE: begin
                    // Only place straps are captured
                    next_st.boot_src = decode_boot(boot_strap_sync);
                    next_st.fallback_ok = decode_fallback(boot_strap_sync);
                    next_st.fallback_used = 1'b0;
                    next_st.clk_cfg = decode_clk(clk_strap_sync);
                    next_st.boot_start = 1'b1;
                    next_st.state = BRC_ST_LOAD;
                end
                BRC_ST_LOAD: begin
                    if (boot_done) begin
                        next_st.fw_loaded = 1'b1;
                        next_st.state = BRC_ST_RUN;
                    end else if (boot_fail) begin
                        if (st.fallback_ok && !st.fallback_used) begin
                            next_st.boot_src = BRC_SRC_USB;
                            next_st.fallback_used = 1'b1;
                            next_st.boot_start = 1'b1;
                        end else begin
                            next_st.state = BRC_ST_FAIL;
                        end
                    end
                end
                BRC_ST_RUN: begin
                    if (whole_edge) begin
                        next_st.state = BRC_ST_HARD;
                        next_st.cnt = '0;
                        next_st.fw_loaded = 1'b0;
                    end else if (cpu_edge) begin
                        next_st.state = BRC_ST_CPU_RST;
                        next_st.cnt = '0;
                    end
                end
                BRC_ST_CPU_RST: begin
                    // Firmware stays loaded through a processor-only reset
                    if (st.cnt == CNT_W'(CPU_RST_CYC - 1)) begin
                        next_st.state = BRC_ST_RUN;
                        next_st.cnt = '0;
                    end else begin
                        next_st.cnt = st.cnt + 1'b1;
                    end
                end
                BRC_ST_FAIL: next_st.state = BRC_ST_FAIL;
                default: next_st.state = BRC_ST_HARD;
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{state: BRC_ST_HARD, cnt: '0, boot_src: BRC_SRC_NONE, fallback_ok: 1'b0,
                    fallback_used: 1'b0, boot_start: 1'b0, fw_loaded: 1'b0, soft_prev: 2'h0,
                    clk_cfg: '{use_crystal: 1'b1, sel_invalid: 1'b0, pll_fb: PLL_FB_19M2,
                               pll_ref: PLL_REF_19M2}};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Raw pin joins here so pins float without waiting on the synchroniser
    assign io_tristate = !nrst || !hard_reset_pin_n || (st.state == BRC_ST_HARD)
                         || (st.state == BRC_ST_SAMPLE);
    assign cpu_reset = (st.state == BRC_ST_HARD) || (st.state == BRC_ST_SAMPLE)
                       || (st.state == BRC_ST_CPU_RST);
    assign boot_start = st.boot_start;
    assign boot_source = st.boot_src;
    assign pin_config_valid = !io_tristate;
    assign usb_fallback_used = st.fallback_used;
    assign fw_loaded = st.fw_loaded;
    assign boot_failed = (st.state == BRC_ST_FAIL);
    assign clk_cfg = st.clk_cfg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Strap pattern as the decoder sees it, floating pins forced to zero
    logic [5:0] strap_pat;
    assign strap_pat = {boot_strap_sync.floating, boot_strap_sync.level & ~boot_strap_sync.floating};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_hard_entry: assert property (!hard_n_sync |=> st.state == BRC_ST_HARD && !fw_loaded)
        else $error("hard reset did not enter reset state");
    a_pins_float: assert property (!hard_reset_pin_n |-> io_tristate)
        else $error("pins driven during hard reset");
    // 125 hold cycles plus sample; the range covers the synchroniser phase
    a_loader_after: assert property (
        $rose(hard_n_sync) ##[1:2] (st.state == BRC_ST_HARD) |-> ##[124:127] boot_start)
        else $error("boot loader not started after release");
    a_straps_held: assert property (
        st.state != BRC_ST_SAMPLE && !(boot_fail && st.state == BRC_ST_LOAD)
        |=> $stable(clk_cfg) && ($stable(boot_source) || !$past(hard_n_sync)))
        else $error("strap decode changed outside sampling");
    // Boot pattern decode, one check each for USB, sync parallel, async parallel and SPI
    a_boot_decode: assert property (
        st.state == BRC_ST_SAMPLE && hard_n_sync && strap_pat == BOOT_PAT_USB
        |=> boot_source == BRC_SRC_USB && boot_start)
        else $error("usb boot strap not decoded");
    a_sync_decode: assert property (
        st.state == BRC_ST_SAMPLE && hard_n_sync && strap_pat == BOOT_PAT_SYNC_ADDRESS_DATA_MULTIPLEXED
        |=> boot_source == BRC_SRC_SYNC_ADDRESS_DATA_MULTIPLEXED && boot_start)
        else $error("sync parallel boot strap not decoded");
    a_async_decode: assert property (
        st.state == BRC_ST_SAMPLE && hard_n_sync && strap_pat == BOOT_PAT_ASYNC_ADDRESS_DATA_MULTIPLEXED
        |=> boot_source == BRC_SRC_ASYNC_ADDRESS_DATA_MULTIPLEXED && boot_start)
        else $error("async parallel boot strap not decoded");
    a_spi_decode: assert property (
        st.state == BRC_ST_SAMPLE && hard_n_sync && strap_pat == BOOT_PAT_SPI_FB
        |=> boot_source == BRC_SRC_SPI && !usb_fallback_used)
        else $error("spi boot strap not decoded");
    a_usb_fallback: assert property (
        st.state == BRC_ST_LOAD && hard_n_sync && boot_fail && !boot_done && st.fallback_ok && !st.fallback_used
        |=> boot_source == BRC_SRC_USB && boot_start && usb_fallback_used)
        else $error("no usb fallback after serial failure");
    a_no_fallback: assert property (
        st.state == BRC_ST_LOAD && hard_n_sync && boot_fail && !boot_done && !st.fallback_ok
        |=> boot_failed)
        else $error("failure without fallback not reported");
    // A stopped boot stays stopped; only a hard reset retries the straps
    a_fail_sticky: assert property (boot_failed && hard_n_sync |=> boot_failed)
        else $error("boot failure flag dropped");
    a_done_wins: assert property (
        st.state == BRC_ST_LOAD && hard_n_sync && boot_done |=> fw_loaded && !boot_failed && !boot_start)
        else $error("loaded image not accepted");
    a_start_pulse: assert property (boot_start |=> !boot_start)
        else $error("boot start longer than one cycle");
    // Soft resets: the short one keeps the image, the long one drops it
    a_cpu_soft: assert property (
        st.state == BRC_ST_RUN && hard_n_sync && cpu_edge && !whole_edge
        |=> (cpu_reset && fw_loaded) [*8] ##3 (!cpu_reset && fw_loaded))
        else $error("cpu soft reset length or firmware retention wrong");
    a_run_clean: assert property (st.state == BRC_ST_RUN |-> !cpu_reset && fw_loaded)
        else $error("processor held while running");
    a_whole_soft: assert property (
        st.state == BRC_ST_RUN && whole_edge |=> io_tristate && !fw_loaded && cpu_reset)
        else $error("whole device reset not like hard reset");
    // Reference decode; a wrong ratio would move every derived clock
    a_pll_ratio: assert property (
        st.state == BRC_ST_SAMPLE && hard_n_sync && clk_strap_sync == CLK_SEL_EXT_26M
        |=> clk_cfg.pll_fb == PLL_FB_26M && clk_cfg.pll_ref == PLL_REF_26M && !clk_cfg.use_crystal)
        else $error("pll ratio wrong for 26 MHz input");
    a_pll_52m: assert property (
        st.state == BRC_ST_SAMPLE && hard_n_sync && clk_strap_sync == CLK_SEL_EXT_52M
        |=> clk_cfg.pll_fb == PLL_FB_52M && clk_cfg.pll_ref == PLL_REF_52M && !clk_cfg.use_crystal)
        else $error("pll ratio wrong for 52 MHz input");
    a_clk_crystal: assert property (
        st.state == BRC_ST_SAMPLE && hard_n_sync && clk_strap_sync == CLK_SEL_XTAL_19M2
        |=> clk_cfg.use_crystal && !clk_cfg.sel_invalid && clk_cfg.pll_fb == PLL_FB_19M2)
        else $error("crystal strap not decoded");

    c_fallback: cover property (st.fallback_used ##[1:50] fw_loaded);
    c_cpu_reset: cover property (st.state == BRC_ST_CPU_RST ##[1:20] st.state == BRC_ST_RUN);
    c_whole_reset: cover property (st.state == BRC_ST_RUN ##1 st.state == BRC_ST_HARD);
    c_boot_ok: cover property (boot_start ##[1:50] fw_loaded);
    c_boot_stop: cover property (boot_start ##[1:50] boot_failed);

endmodule : brc_boot_reset_clock

// ===== dv/brc_loader_model.sv
// Behavioural boot media and loader seen from the configuration block.
// Assumes boot_start is a one-cycle pulse and boot_source is valid with it.
`timescale 1ns/1ps
module brc_loader_model
    import brc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic boot_start,
    input wire brc_src_e boot_source,
    input wire logic serial_bad,
    input wire logic [3:0] resp_delay,
    output logic boot_done,
    output logic boot_fail
);
    logic busy;
    logic bad;
    logic [3:0] wait_cnt;

    // One answer per start; a blank serial memory fails, USB always loads
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            bad <= 1'b0;
            wait_cnt <= 4'h0;
            boot_done <= 1'b0;
            boot_fail <= 1'b0;
        end else begin
            boot_done <= 1'b0;
            boot_fail <= 1'b0;
            if (boot_start) begin
                busy <= 1'b1;
                wait_cnt <= resp_delay;
                bad <= serial_bad && (boot_source == BRC_SRC_I2C || boot_source == BRC_SRC_SPI);
            end else if (busy && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                boot_done <= !bad;
                boot_fail <= bad;
            end
        end
    end
endmodule : brc_loader_model

// ===== dv/tb_brc_boot_reset_clock.sv
// Self-checking bench for the boot, reset and clock configuration block.
// Assumes the loader model answers every boot_start; straps are also scrambled while running.
`timescale 1ns/1ps
module tb_brc_boot_reset_clock;
    import brc_pkg::*;
    logic ref_clk, nrst, hard_reset_pin_n, boot_done, boot_fail, serial_bad;
    logic [2:0] boot_select_straps, boot_select_float, clock_freq_select_straps;
    logic [1:0] soft_reset_control;
    logic [3:0] resp_delay;
    logic io_tristate, cpu_reset, boot_start, pin_config_valid, usb_fallback_used, fw_loaded, boot_failed;
    brc_src_e boot_source;
    brc_clk_cfg_s clk_cfg;
    int errors, checks, n;
    logic [5:0] boot_tab [8] = '{BOOT_PAT_SYNC_ADDRESS_DATA_MULTIPLEXED, BOOT_PAT_ASYNC_ADDRESS_DATA_MULTIPLEXED, BOOT_PAT_USB, BOOT_PAT_I2C_ONLY,
        BOOT_PAT_I2C_FB, BOOT_PAT_SPI_FB, BOOT_PAT_ASYNC_SRAM, 6'h00};
    brc_src_e src_tab [8] = '{BRC_SRC_SYNC_ADDRESS_DATA_MULTIPLEXED, BRC_SRC_ASYNC_ADDRESS_DATA_MULTIPLEXED, BRC_SRC_USB, BRC_SRC_I2C,
        BRC_SRC_I2C, BRC_SRC_SPI, BRC_SRC_ASYNC_SRAM, BRC_SRC_NONE};
    logic [2:0] clk_tab [8] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3};

    brc_boot_reset_clock u_dut (.ref_clk(ref_clk), .nrst(nrst), .hard_reset_pin_n(hard_reset_pin_n),
        .boot_select_straps(boot_select_straps), .boot_select_float(boot_select_float),
        .clock_freq_select_straps(clock_freq_select_straps), .soft_reset_control(soft_reset_control),
        .boot_done(boot_done), .boot_fail(boot_fail), .io_tristate(io_tristate), .cpu_reset(cpu_reset),
        .boot_start(boot_start), .boot_source(boot_source), .pin_config_valid(pin_config_valid),
        .usb_fallback_used(usb_fallback_used), .fw_loaded(fw_loaded), .boot_failed(boot_failed),
        .clk_cfg(clk_cfg));

    brc_loader_model u_loader (.ref_clk(ref_clk), .nrst(nrst), .boot_start(boot_start),
        .boot_source(boot_source), .serial_bad(serial_bad), .resp_delay(resp_delay),
        .boot_done(boot_done), .boot_fail(boot_fail));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // Inputs always move 1 ns after the edge, clear of sampling
    task automatic step(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : step

    function automatic logic sig_of(input int k);
        case (k)
            0: return boot_start;
            1: return fw_loaded;
            default: return boot_failed;
        endcase
    endfunction : sig_of

    task automatic wait_sig(input string name, input int k, input int max);
        n = 0;
        while (sig_of(k) !== 1'b1) begin
            step(1);
            n++;
            if (n > max) begin
                errors++;
                $display("wrong value %s expected 1 seen timeout", name);
                give_verdict();
            end
        end
    endtask : wait_sig

    function automatic brc_clk_cfg_s exp_clk(input logic [2:0] c);
        case (c)
            CLK_SEL_XTAL_19M2: return '{1'b1, 1'b0, PLL_FB_19M2, PLL_REF_19M2};
            CLK_SEL_EXT_19M2: return '{1'b0, 1'b0, PLL_FB_19M2, PLL_REF_19M2};
            CLK_SEL_EXT_26M: return '{1'b0, 1'b0, PLL_FB_26M, PLL_REF_26M};
            CLK_SEL_EXT_38M4: return '{1'b0, 1'b0, PLL_FB_38M4, PLL_REF_38M4};
            CLK_SEL_EXT_52M: return '{1'b0, 1'b0, PLL_FB_52M, PLL_REF_52M};
            default: return '{1'b1, 1'b1, PLL_FB_19M2, PLL_REF_19M2};
        endcase
    endfunction : exp_clk

    // Full hard reset through the pin, ending in the boot_start cycle
    task automatic hard_boot(input logic [5:0] pat, input logic [2:0] ck, input brc_src_e src);
        hard_reset_pin_n = 1'b0;
        boot_select_float = pat[5:3];
        boot_select_straps = pat[2:0];
        clock_freq_select_straps = ck;
        #1;
        chk("io_tristate", 16'(io_tristate), 16'h1);
        step(4);
        chk("cpu_reset", 16'(cpu_reset), 16'h1);
        chk("fw_loaded", 16'(fw_loaded), 16'h0);
        hard_reset_pin_n = 1'b1;
        wait_sig("boot_start", 0, 200);
        chk("boot delay", 16'(n >= 124 && n <= 130), 16'h1);
        chk("boot_source", 16'(boot_source), 16'(src));
        chk("clk_cfg", 16'(clk_cfg), 16'(exp_clk(ck)));
        chk("pin_config_valid", 16'(pin_config_valid), 16'h1);
        chk("cpu_reset", 16'(cpu_reset), 16'h0);
    endtask : hard_boot

    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        errors = 0;
        checks = 0;
        nrst = 1'b0;
        hard_reset_pin_n = 1'b1;
        boot_select_straps = 3'h3;
        boot_select_float = 3'h4;
        clock_freq_select_straps = 3'h0;
        soft_reset_control = 2'h0;
        serial_bad = 1'b0;
        resp_delay = 4'h0;
        step(20);
        chk("io_tristate", 16'(io_tristate), 16'h1);
        chk("boot_source", 16'(boot_source), 16'(BRC_SRC_NONE));
        nrst = 1'b1;
        // Every listed boot pattern plus 00, every clock code, then straps scrambled while running must not matter
        for (int i = 0; i < 8; i++) begin
            hard_boot(boot_tab[i], clk_tab[i], src_tab[i]);
            boot_select_straps = ~boot_tab[i][2:0];
            boot_select_float = ~boot_tab[i][5:3];
            clock_freq_select_straps = ~clk_tab[i];
            step(6);
            chk("held source", 16'(boot_source), 16'(src_tab[i]));
            chk("held clk_cfg", 16'(clk_cfg), 16'(exp_clk(clk_tab[i])));
        end
        $display("test strap decode done");
        // Serial loads fail with a slow loader: fall back or stop
        serial_bad = 1'b1;
        resp_delay = 4'h9;
        for (int j = 0; j < 2; j++) begin
            hard_boot(j == 0 ? BOOT_PAT_I2C_FB : BOOT_PAT_SPI_FB, CLK_SEL_EXT_26M, j == 0 ? BRC_SRC_I2C : BRC_SRC_SPI);
            step(2);
            wait_sig("fallback start", 0, 40);
            chk("fallback source", 16'(boot_source), 16'(BRC_SRC_USB));
            chk("usb_fallback_used", 16'(usb_fallback_used), 16'h1);
            wait_sig("fw_loaded", 1, 40);
        end
        hard_boot(BOOT_PAT_I2C_ONLY, CLK_SEL_EXT_52M, BRC_SRC_I2C);
        wait_sig("boot_failed", 2, 40);
        chk("no fallback", 16'(usb_fallback_used), 16'h0);
        chk("source kept", 16'(boot_source), 16'(BRC_SRC_I2C));
        serial_bad = 1'b0;
        $display("test fallback done");
        // Processor-only reset keeps firmware
        hard_boot(BOOT_PAT_USB, CLK_SEL_EXT_38M4, BRC_SRC_USB);
        wait_sig("fw_loaded", 1, 40);
        soft_reset_control = 2'h1;
        step(1);
        chk("cpu_reset", 16'(cpu_reset), 16'h1);
        n = 0;
        while (cpu_reset === 1'b1 && n < 40) begin
            n++;
            step(1);
        end
        chk("cpu reset length", 16'(n), 16'(CPU_RST_CYC));
        chk("fw kept", 16'(fw_loaded), 16'h1);
        chk("io live", 16'(io_tristate), 16'h0);
        soft_reset_control = 2'h0;
        step(2);
        $display("test cpu reset done");
        // Whole-device reset repeats the hard sequence
        soft_reset_control = 2'h2;
        step(2);
        chk("io_tristate", 16'(io_tristate), 16'h1);
        chk("cpu_reset", 16'(cpu_reset), 16'h1);
        chk("fw_loaded", 16'(fw_loaded), 16'h0);
        soft_reset_control = 2'h0;
        wait_sig("reboot start", 0, 200);
        chk("reboot delay", 16'(n >= 118 && n <= 130), 16'h1);
        chk("reboot source", 16'(boot_source), 16'(BRC_SRC_USB));
        wait_sig("reload", 1, 40);
        $display("test device reset done");
        give_verdict();
    end
endmodule : tb_brc_boot_reset_clock
